// ### rtl/sewp_top.v
// spi eeprom write latch, status byte and write protection
// Functional notes
// - set-latch command sets the write latch, clear-latch command clears it.
// - no array or status write completes unless the latch was set first.
// - latch clears at power-up and after clear-latch, status write, array write.
// - status read works at any time, even during an internal write.
// - status byte: enable bit 7, guards bits 3-2, latch bit 1, busy 0.
// - busy reads 1 during an internal write, else 0; never written.
// - latch flag follows latch; latch commands work despite hardware protection.
// - guard bits are nonvolatile, changed only by status write.
// - guards 00 none, 01 1800h-1FFFh, 10 1000h-1FFFh, 11 whole array.
// - status read repeats the status byte while chip select stays low.
// - hardware protection only when protect pin low and enable bit set.
// - hardware protection blocks only nonvolatile status writes, nothing else.
// - status write cycle starts on chip select rising after a valid sequence.
// - array commands are ignored during an internal write cycle.
// - power-on in standby, latch clear, output off; select high first.
// - latch clear refuses all writes; set allows unguarded array and status.
// - deselect does not stop a started write; standby after it ends.
// - serial output is high impedance whenever chip select is high.
// - protect pin falling during a started write does not affect it.
// - input captured on rising serial clock, output changed after falling.
// - opcodes msb first: set 06h, clear 04h, status read 05h.
// - status write opcode 01h followed by one data byte.
`include "sewp_regs.vh"
`default_nettype none

module sewp_top #(
	parameter P_TWC_CYC = `SEWP_TWC_CYC
) (
	// clock, reset, enable
	input  wire                 i_ref_clk,
	input  wire                 i_rst_n,
	input  wire                 i_clk_en,
	// serial pins
	input  wire                 i_cs_n,
	input  wire                 i_sck,
	input  wire                 i_si,
	input  wire                 i_wp_n,
	output wire                 o_so,
	output wire                 o_so_oe_n,
	// nonvolatile cell for enable and guard bits
	input  wire [2:0]           i_nv_bits,
	output wire [2:0]           o_nv_bits,
	output wire                 o_nv_wr,
	// array write side
	output wire                 o_arr_wr_go,
	output wire [`SEWP_AW-1:0]  o_arr_addr,
	// state
	output wire                 o_busy,
	output wire                 o_latch,
	output wire                 o_standby
);

	// ==========================================
	// sequence states
	localparam [2:0] ST_OPC  = 3'h0;
	localparam [2:0] ST_SRD  = 3'h1;
	localparam [2:0] ST_ADDR = 3'h2;
	localparam [2:0] ST_WDAT = 3'h3;
	localparam [2:0] ST_STATUS_READ_CMD = 3'h4;
	localparam [2:0] ST_HOLD = 3'h5;
	localparam [2:0] ST_IGN  = 3'h6;

	localparam [31:0] OPC_LAST32  = `SEWP_OPC_BITS - 1;
	localparam [31:0] ADDR_LAST32 = `SEWP_ADDR_BITS - 1;
	localparam [4:0]  OPC_LAST    = OPC_LAST32[4:0];
	localparam [4:0]  ADDR_LAST   = ADDR_LAST32[4:0];

	// ==========================================
	// guarded address decode
	// guard range decode
	function f_guarded;
		input [`SEWP_AW-1:0] a;
		input [1:0]          bp;
		begin
			case (bp)
				2'h0:    f_guarded = 1'b0;
				2'h1:    f_guarded = (a >= `SEWP_QTR_BASE);
				2'h2:    f_guarded = (a >= `SEWP_HALF_BASE);
				default: f_guarded = 1'b1;
			endcase
		end
	endfunction

	// ==========================================
	// reset release
	reg rst_m_r;
	reg rst_s_r;
	wire rst_n;

	// async assert, release after two edges
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else if (i_clk_en) begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end

	assign rst_n = rst_s_r;

	// ==========================================
	// pin synchronisers
	wire [3:0] pin_s;
	wire       cs_s;
	wire       sck_s;
	wire       si_s;
	wire       wp_s;

	// all pins reset low so select needs a real high first
	sewp_sync #(
		.W  (4),
		.RV (4'h0)
	) u_sync (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_n),
		.i_ce    (i_clk_en),
		.i_d     ({i_cs_n, i_sck, i_si, i_wp_n}),
		.o_q     (pin_s)
	);

	assign cs_s  = pin_s[3];
	assign sck_s = pin_s[2];
	assign si_s  = pin_s[1];
	assign wp_s  = pin_s[0];

	// ==========================================
	// write cycle timer
	wire busy;
	wire wc_done;
	reg  wc_start_r;

	sewp_wcycle #(
		.CYC (P_TWC_CYC)
	) u_wcycle (
		.i_clk   (i_ref_clk),
		.i_rst_n (rst_n),
		.i_ce    (i_clk_en),
		.i_start (wc_start_r),
		.o_busy  (busy),
		.o_done  (wc_done)
	);

	// ==========================================
	// state registers
	reg [2:0]          state_r;
	reg [4:0]          cnt_r;
	reg [2:0]          dbit_r;
	reg                gotb_r;
	reg [7:0]          sh_r;
	reg [7:0]          cmd_r;
	reg [`SEWP_AW-1:0] addr_r;
	reg                sck_d_r;
	reg                cs_d_r;
	reg                armed_r;
	reg                latch_r;
	reg                pen_r;
	reg [1:0]          bp_r;
	reg                nv_ld_r;
	reg                sr_pend_r;
	reg [2:0]          sr_new_r;
	reg                nv_wr_r;
	reg                arr_go_r;
	reg                so_r;
	reg                oe_n_r;
	reg [2:0]          oidx_r;
	reg [7:0]          snap_r;

	// ==========================================
	// edges and combined terms
	wire       sck_rise;
	wire       sck_fall;
	wire       cs_rise;
	wire       sel;
	wire       hw_prot;
	wire [7:0] sh_nxt;
	wire [7:0] status;
	wire       sr_ok;
	wire       arr_ok;

	// edges found on the synchronised copies only
	assign sck_rise = sck_s & ~sck_d_r;
	assign sck_fall = ~sck_s & sck_d_r;
	assign cs_rise  = cs_s & ~cs_d_r;
	assign sel      = ~cs_s & armed_r;
	assign sh_nxt   = {sh_r[6:0], si_s};

	assign hw_prot  = ~wp_s & pen_r;

	assign status   = {pen_r, 3'h0, bp_r, latch_r, busy};

	assign sr_ok    = latch_r & ~hw_prot & ~busy;

	assign arr_ok   = latch_r & ~busy & gotb_r & (dbit_r == 3'h0) &
	                  ~f_guarded(addr_r, bp_r);

	// ==========================================
	// nonvolatile bits
	// loaded from the cell once after reset release; an async reset can
	// only take a constant, so the cell value comes in by a clocked load
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pen_r   <= 1'b0;
			bp_r    <= 2'h0;
			nv_ld_r <= 1'b0;
			nv_wr_r <= 1'b0;
		end else if (i_clk_en) begin
			nv_wr_r <= 1'b0;
			if (!nv_ld_r) begin
				{pen_r, bp_r} <= i_nv_bits;
				nv_ld_r       <= 1'b1;
			end else if (wc_done && sr_pend_r) begin
				{pen_r, bp_r} <= sr_new_r;
				nv_wr_r       <= 1'b1;
			end
		end
	end

	// ==========================================
	// serial sequence engine
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= ST_OPC;
			cnt_r      <= 5'h0;
			dbit_r     <= 3'h0;
			gotb_r     <= 1'b0;
			sh_r       <= 8'h00;
			cmd_r      <= 8'h00;
			addr_r     <= {`SEWP_AW{1'b0}};
			sck_d_r    <= 1'b0;
			cs_d_r     <= 1'b0;
			armed_r    <= 1'b0;
			latch_r    <= 1'b0;
			sr_pend_r  <= 1'b0;
			sr_new_r   <= `SEWP_NV_RST;
			wc_start_r <= 1'b0;
			arr_go_r   <= 1'b0;
		end else if (i_clk_en) begin
			sck_d_r    <= sck_s;
			cs_d_r     <= cs_s;
			wc_start_r <= 1'b0;
			arr_go_r   <= 1'b0;
			if (cs_s) begin
				armed_r <= 1'b1;
			end
			if (wc_done) begin
				sr_pend_r <= 1'b0;
			end
			if (!sel) begin
				// deselect restarts the frame, never the timer
				state_r <= ST_OPC;
				cnt_r   <= 5'h0;
				dbit_r  <= 3'h0;
				gotb_r  <= 1'b0;
				if (cs_rise && armed_r) begin
					case (cmd_r)
						`SEWP_OPC_SETL: begin
							if (state_r == ST_HOLD) begin
								latch_r <= 1'b1;
							end
						end
						`SEWP_OPC_CLRL: begin
							if (state_r == ST_HOLD) begin
								latch_r <= 1'b0;
							end
						end
						`SEWP_OPC_STATUS_WRITE_CMD: begin
							if (state_r == ST_HOLD && sr_ok) begin
								sr_new_r   <= {sh_r[`SEWP_SR_PEN], sh_r[`SEWP_SR_BP_HI],
								               sh_r[`SEWP_SR_BP_LO]};
								sr_pend_r  <= 1'b1;
								wc_start_r <= 1'b1;
								latch_r    <= 1'b0;
							end
						end
						`SEWP_OPC_WRITE: begin
							if (state_r == ST_WDAT && arr_ok) begin
								arr_go_r   <= 1'b1;
								wc_start_r <= 1'b1;
								latch_r    <= 1'b0;
							end
						end
						default: begin
							cmd_r <= cmd_r;
						end
					endcase
				end
			end else if (sck_rise) begin
				sh_r <= sh_nxt;
				case (state_r)
					ST_OPC: begin
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == OPC_LAST) begin
							cnt_r <= 5'h0;
							cmd_r <= sh_nxt;
							case (sh_nxt)
								`SEWP_OPC_SETL:  state_r <= ST_HOLD;
								`SEWP_OPC_CLRL:  state_r <= ST_HOLD;
								`SEWP_OPC_STATUS_READ_CMD:  state_r <= ST_STATUS_READ_CMD;
								`SEWP_OPC_STATUS_WRITE_CMD:  state_r <= ST_SRD;
								`SEWP_OPC_WRITE: state_r <= busy ? ST_IGN : ST_ADDR;
								default:         state_r <= ST_IGN;
							endcase
						end
					end
					ST_SRD: begin
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == OPC_LAST) begin
							state_r <= ST_HOLD;
						end
					end
					ST_ADDR: begin
						// upper address bits fall off the top
						addr_r <= {addr_r[`SEWP_AW-2:0], si_s};
						cnt_r  <= cnt_r + 1'b1;
						if (cnt_r == ADDR_LAST) begin
							state_r <= ST_WDAT;
						end
					end
					ST_WDAT: begin
						// data bits are only counted; the byte is not passed to the array path
						dbit_r <= dbit_r + 1'b1;
						if (dbit_r == 3'h7) begin
							gotb_r <= 1'b1;
						end
					end
					ST_HOLD: begin
						// extra clocks spoil a complete frame
						state_r <= ST_IGN;
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
		end
	end

	// ==========================================
	// serial output
	// status is snapped at each byte start so a byte
	// never mixes two values of the busy flag
	always @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			so_r   <= 1'b0;
			oe_n_r <= 1'b1;
			oidx_r <= 3'h0;
			snap_r <= 8'h00;
		end else if (i_clk_en) begin
			if (!sel) begin
				oe_n_r <= 1'b1;
				oidx_r <= 3'h0;
			end else if (sck_fall && state_r == ST_STATUS_READ_CMD) begin
				oe_n_r <= 1'b0;
				oidx_r <= oidx_r + 1'b1;
				if (oidx_r == 3'h0) begin
					snap_r <= status;
					so_r   <= status[7];
				end else begin
					so_r   <= snap_r[~oidx_r];
				end
			end
		end
	end

	// ==========================================
	// outputs
	assign o_so        = so_r;
	assign o_so_oe_n   = oe_n_r;
	assign o_nv_bits   = {pen_r, bp_r};
	assign o_nv_wr     = nv_wr_r;
	assign o_arr_wr_go = arr_go_r;
	assign o_arr_addr  = addr_r;
	assign o_busy      = busy;
	assign o_latch     = latch_r;
	assign o_standby   = cs_s & ~busy;

endmodule
`default_nettype wire

// ### rtl/sewp_regs.vh
// constants of the serial protect and status block
`ifndef SEWP_REGS_VH
`define SEWP_REGS_VH

// ==========================================
// command opcodes, msb first on the wire
`define SEWP_OPC_SETL    8'h06
`define SEWP_OPC_CLRL    8'h04
`define SEWP_OPC_STATUS_READ_CMD    8'h05
`define SEWP_OPC_STATUS_WRITE_CMD    8'h01
`define SEWP_OPC_WRITE   8'h02
`define SEWP_OPC_READ    8'h03

// ==========================================
// status byte layout
`define SEWP_SR_PEN      7
`define SEWP_SR_BP_HI    3
`define SEWP_SR_BP_LO    2
`define SEWP_SR_LATCH    1
`define SEWP_SR_BUSY     0
`define SEWP_SR_WMASK    8'h8C
`define SEWP_NV_RST      3'h0

// ==========================================
// array geometry and guarded ranges
`define SEWP_AW          13
`define SEWP_QTR_BASE    13'h1800
`define SEWP_HALF_BASE   13'h1000

// ==========================================
// frame bit counts
`define SEWP_OPC_BITS    8
`define SEWP_ADDR_BITS   16

// ==========================================
// write cycle time, longest, rounded down
`define SEWP_TWC_MS      5
`define SEWP_CLK_HZ      40000000
`define SEWP_TWC_CYC     (`SEWP_TWC_MS * (`SEWP_CLK_HZ / 1000))

`endif

// ### rtl/sewp_sync.v
// two flip-flop synchroniser for asynchronous pin levels
`default_nettype none

module sewp_sync #(
	parameter         W  = 4,
	parameter [W-1:0] RV = {W{1'b0}}
) (
	// clock, reset, enable
	input  wire         i_clk,
	input  wire         i_rst_n,
	input  wire         i_ce,
	// pin levels in, synchronised out
	input  wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	// ==========================================
	// first stage feeds only the second stage
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= RV;
			sync_r <= RV;
		end else if (i_ce) begin
			meta_r <= i_d;
			sync_r <= meta_r;
		end
	end

	assign o_q = sync_r;

endmodule
`default_nettype wire

// ### rtl/sewp_wcycle.v
// self-timed internal write cycle timer
`default_nettype none

module sewp_wcycle #(
	parameter CYC = 200000,
	parameter CW  = $clog2(CYC + 1)
) (
	// clock, reset, enable
	input  wire i_clk,
	input  wire i_rst_n,
	input  wire i_ce,
	// start pulse in, busy level and done pulse out
	input  wire i_start,
	output wire o_busy,
	output wire o_done
);

	localparam [31:0] LAST32 = CYC - 1;

	reg [CW-1:0] cnt_r;
	reg          busy_r;
	reg          done_r;

	// ==========================================
	// count down; a start while busy is dropped
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r  <= {CW{1'b0}};
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (i_ce) begin
			done_r <= 1'b0;
			if (!busy_r) begin
				if (i_start) begin
					cnt_r  <= LAST32[CW-1:0];
					busy_r <= 1'b1;
				end
			end else if (cnt_r == {CW{1'b0}}) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	assign o_busy = busy_r;
	assign o_done = done_r;

endmodule
`default_nettype wire

// ### dv/sewp_top_sva.sv
// assertion checker on the pins of sewp_top
`default_nettype none
module sewp_top_sva #(
	parameter P_TWC_CYC = 500
) (
	// clock and reset
	input wire       i_ref_clk,
	input wire       i_rst_n,
	input wire       i_clk_en,
	// pins and state
	input wire       i_cs_n,
	input wire       o_so_oe_n,
	input wire [2:0] o_nv_bits,
	input wire       o_nv_wr,
	input wire       o_arr_wr_go,
	input wire       o_busy,
	input wire       o_latch,
	input wire       o_standby
);
	// =====
	// helpers
	logic [2:0] rc_r;
	int         bc_r;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// settle count after reset, length of busy run
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rc_r <= 3'h0;
			bc_r <= 0;
		end else begin
			if (rc_r != 3'h7) rc_r <= rc_r + 3'h1;
			// frozen cycles do not advance the write timer
			if (i_clk_en) bc_r <= o_busy ? bc_r + 1 : 0;
		end
	end
	// =====
	// properties
	sequence s_go_busy;
		($past(o_latch) && !o_latch) ##1 o_busy;
	endsequence
	property p_oe_off; i_cs_n [*5] |-> o_so_oe_n; endproperty
	a_oe_off: assert property (p_oe_off) else $error("so driven while deselected");
	property p_oe_on; $fell(o_so_oe_n) |-> !$past(i_cs_n, 4); endproperty
	a_oe_on: assert property (p_oe_on) else $error("so enabled without select");
	property p_nvwr; o_nv_wr |-> $past(o_busy, 2) && !$past(o_busy); endproperty
	a_nvwr: assert property (p_nvwr) else $error("store pulse off cycle end");
	property p_nv_hold; (rc_r == 3'h7 && !o_nv_wr) |-> $stable(o_nv_bits); endproperty
	a_nv_hold: assert property (p_nv_hold) else $error("guard bits moved");
	property p_busy_len; $fell(o_busy) |-> bc_r == P_TWC_CYC; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_busy_latch; $rose(o_busy) |-> $past(o_latch, 2) && !$past(o_latch); endproperty
	a_busy_latch: assert property (p_busy_latch) else $error("write without latch");
	property p_go; o_arr_wr_go |-> s_go_busy; endproperty
	a_go: assert property (p_go) else $error("latch not cleared by write");
	property p_go_idle; o_arr_wr_go |-> !$past(o_busy); endproperty
	a_go_idle: assert property (p_go_idle) else $error("write taken while busy");
	property p_stby; (i_cs_n && rc_r == 3'h7) [*5] |-> o_standby == !o_busy; endproperty
	a_stby: assert property (p_stby) else $error("standby wrong");
endmodule
bind sewp_top sewp_top_sva #(.P_TWC_CYC(P_TWC_CYC)) u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_cs_n(i_cs_n), .o_so_oe_n(o_so_oe_n), .o_nv_bits(o_nv_bits), .o_nv_wr(o_nv_wr),
	.o_arr_wr_go(o_arr_wr_go), .o_busy(o_busy), .o_latch(o_latch), .o_standby(o_standby));
`default_nettype wire

// ### dv/sewp_host.sv
// spi host model for the serial pins
`default_nettype none
module sewp_host (
	// clock and returned data
	input  wire logic i_clk,
	input  wire logic i_so,
	input  wire logic i_so_oe_n,
	// driven pins
	output var  logic o_cs_n,
	output var  logic o_sck,
	output var  logic o_si
);
	timeunit 1ns;
	timeprecision 100ps;
	logic so_w;
	// released output floats
	assign so_w = i_so_oe_n ? 1'bz : i_so;
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
	end
	// n clocks, then step off the edge
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic sel();
		tick(1);
		o_cs_n = 1'b0;
		tick(4);
	endtask
	// msb first, drive low, sample at rise
	task automatic xb(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			o_si = b[i];
			tick(4);
			o_sck = 1'b1;
			r[i] = so_w;
			tick(4);
			o_sck = 1'b0;
		end
	endtask
	// release on byte boundary; sck rests, si flips
	task automatic desel();
		tick(4);
		o_cs_n = 1'b1;
		o_si = ~o_si;
		tick(4);
	endtask
endmodule
`default_nettype wire

// ### dv/sewp_top_tb.sv
// self-checking bench for sewp_top
`include "sewp_regs.vh"
`default_nettype none
module sewp_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TWC = 500;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wp_n = 1'b1;
	logic ce = 1'b1;
	logic [2:0] nv_in = 3'h0;
	wire cs_n, sck, si, so, oe_n, nv_wr, go, busy, latch, stby;
	wire [2:0] nv;
	wire [12:0] addr;
	logic [12:0] ta [3] = '{13'h0FFF, 13'h17FF, 13'h1800};
	int seed = 32'he271;
	int bad_count = 0;
	int cmp_count = 0;
	int go_n = 0;
	int tn = 0;
	int m_l = 0, m_b = 0, m_pen = 0, m_bp = 0;
	// clock and pulse count
	always #12.5 clk = ~clk;
	always @(posedge clk) if (go === 1'b1) go_n++;
	// nonvolatile cell keeps what the design stores
	always @(posedge clk) if (nv_wr === 1'b1) nv_in <= nv;
	sewp_top #(.P_TWC_CYC(TWC)) u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce),
		.i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(wp_n), .o_so(so), .o_so_oe_n(oe_n),
		.i_nv_bits(nv_in), .o_nv_bits(nv), .o_nv_wr(nv_wr), .o_arr_wr_go(go), .o_arr_addr(addr),
		.o_busy(busy), .o_latch(latch), .o_standby(stby));
	sewp_host u_host (.i_clk(clk), .i_so(so), .i_so_oe_n(oe_n), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
	// =====
	// checking and model
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic done();
		tn++;
		$display("test %0d done", tn);
	endtask
	function automatic logic [7:0] sr(int b);
		return {m_pen[0], 3'h0, m_bp[1:0], m_l[0], b[0]};
	endfunction
	function automatic int guarded(int a);
		case (m_bp)
			1: return a >= 13'h1800;
			2: return a >= 13'h1000;
			3: return 1;
			default: return 0;
		endcase
	endfunction
	// bounded wait for the write cycle
	task automatic idle();
		for (int i = 0; i < 4000; i++) begin
			// new guard bits land one edge after busy drops
			if (busy === 1'b0) begin
				u_host.tick(2);
				return;
			end
			u_host.tick(1);
		end
		bad_count++;
		print_verdict();
	endtask
	// =====
	// frames
	task automatic cmd(input logic [7:0] op);
		logic [7:0] r;
		u_host.sel();
		u_host.xb(op, r);
		u_host.desel();
		u_host.tick(4);
	endtask
	task automatic setl();
		cmd(`SEWP_OPC_SETL);
		m_l = 1;
		chk(latch, m_l);
	endtask
	task automatic clrl();
		cmd(`SEWP_OPC_CLRL);
		m_l = 0;
		chk(latch, m_l);
	endtask
	task automatic status_read_cmd(input logic [7:0] e);
		logic [7:0] r;
		u_host.sel();
		u_host.xb(`SEWP_OPC_STATUS_READ_CMD, r);
		repeat (2) begin
			u_host.xb(8'($random(seed)), r);
			chk(r & 8'h8F, e);
		end
		u_host.desel();
	endtask
	task automatic aw(input logic [15:0] a);
		logic [7:0] r;
		int g0;
		int ok;
		g0 = go_n;
		ok = m_l && !m_b && !guarded(a[12:0]);
		u_host.sel();
		u_host.xb(`SEWP_OPC_WRITE, r);
		u_host.xb(a[15:8], r);
		u_host.xb(a[7:0], r);
		u_host.xb(8'($random(seed)), r);
		u_host.desel();
		u_host.tick(4);
		chk(go_n - g0, ok);
		if (ok) m_l = 0;
		if (ok) chk(addr, a[12:0]);
		chk(latch, m_l);
		idle();
	endtask
	// md 1: wp falls and array write during busy; md 2: surplus byte
	task automatic sw(input logic [7:0] d, input int md);
		logic [7:0] r;
		int ok;
		ok = m_l && !(m_pen && !wp_n) && md != 2;
		u_host.sel();
		u_host.xb(`SEWP_OPC_STATUS_WRITE_CMD, r);
		u_host.xb(d, r);
		if (md == 2) u_host.xb(d, r);
		u_host.desel();
		u_host.tick(4);
		chk(busy, ok);
		if (ok) m_l = 0;
		chk(latch, m_l);
		m_b = ok;
		if (md == 1) begin
			wp_n = 1'b0;
			setl();
			aw(16'h0000);
		end else if (ok) status_read_cmd(sr(1));
		idle();
		m_b = 0;
		if (ok) m_pen = d[7];
		if (ok) m_bp = d[3:2];
		chk(nv, {m_pen[0], m_bp[1:0]});
		status_read_cmd(sr(0));
	endtask
	// =====
	// main sequence
	initial begin
		nv_in = 3'($random(seed));
		m_pen = nv_in[2];
		m_bp = nv_in[1:0];
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		u_host.tick(8);
		chk(nv, nv_in);
		chk(oe_n, 1);
		chk(stby, 1);
		status_read_cmd(sr(0));
		sw(8'h0C, 0);
		setl();
		// frozen clock enable: a whole frame goes unseen
		ce = 1'b0;
		cmd(`SEWP_OPC_CLRL);
		ce = 1'b1;
		u_host.tick(4);
		chk(latch, m_l);
		clrl();
		done();
		for (int g = 0; g < 4; g++) begin
			setl();
			sw({1'b0, 3'($random(seed)), 2'(g), 2'($random(seed))}, 0);
			foreach (ta[i]) begin
				setl();
				aw({3'($random(seed)), ta[i]});
			end
			done();
		end
		setl();
		sw(8'h80, 1);
		setl();
		sw(8'h00, 0);
		clrl();
		aw(16'h0000);
		setl();
		aw(16'h0000);
		wp_n = 1'b1;
		setl();
		sw(8'h00, 2);
		sw(8'h00, 0);
		done();
		// power cycle in mid-run: latch lost, guard bits kept
		setl();
		sw(8'h88, 0);
		setl();
		rst_n = 1'b0;
		u_host.tick(3);
		rst_n = 1'b1;
		u_host.tick(8);
		m_l = 0;
		chk(latch, m_l);
		chk(nv, {m_pen[0], m_bp[1:0]});
		chk(oe_n, 1);
		status_read_cmd(sr(0));
		done();
		print_verdict();
	end
endmodule
`default_nettype wire
